// file: rh_readout.sv
// Purpose: Command, heater, result and pulse-width logic of a humidity sensor.
// Assumes: Bus pins arrive asynchronously; the converter runs on i_clock.
// Notes: The pulse-width variant is chosen by parameter only.
`default_nettype none
`include "rh_cfg.svh"
// ==========================================================
// Functional notes
// RULE1: Humidity word passes linearly, unaltered.
// RULE2: Host clamps humidity to zero..hundred percent.
// RULE3: Fixed serial number, two words, checksummed.
// RULE4: Heater: three powers by two durations.
// RULE5: Heater command starts heater and countdown.
// RULE6: Countdown end starts high measurement, heater on.
// RULE7: Heater off, then results become readable.
// RULE8: Heater at most one second, no off.
// RULE9: Host repeats commands, duty below ten percent.
// RULE10: Host polls to re-issue heater command quickly.
// RULE11: Pulse-width variant fixed, not user selectable.
// RULE12: Pulse-width outputs valid within ten milliseconds.
// RULE13: Constant base period, data as duty.
// RULE14: Humidity duty tenth to nine tenths linear.
// RULE15: Temperature duty uses same linear span.
// RULE16: Soft-reset command resets the device.
// RULE17: General call byte six resets everyone.
// RULE18: Read header refused while busy.
// RULE19: Six heater codes, six byte answer.
// RULE20: Each word followed by CRC-8.
// RULE21: Temperature pair first, humidity pair second.
// RULE22: Pulse width changes only at period edges.
module rh_readout #(
  parameter bit PWM_VARIANT = 1'b0,
  parameter logic [31:0] SERIAL_NUMBER = 32'h1234_5678, // Arbitrary value.
  parameter int HEAT_LONG_CYC = `RH_HEAT_LONG_CYC,
  parameter int HEAT_SHORT_CYC = `RH_HEAT_SHORT_CYC,
  parameter int PWM_PERIOD = `RH_PWM_PERIOD_CYC,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  output rh_pkg::heater_s o_heater,
  output logic o_conv_req,
  output rh_pkg::rep_e o_conv_rep,
  input wire logic i_conv_done,
  input wire rh_pkg::meas_s i_conv_data
);
  import rh_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] crc8(input logic [15:0] word);
    logic [7:0] c;
    c = `RH_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = c[7] ^ word[i] ? {c[6:0], 1'b0} ^ `RH_CRC_POLY : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  function automatic logic [15:0] pwm_width(input logic [15:0] word);
    logic [31:0] span;
    logic [31:0] prod;
    span = 32'(PWM_PERIOD * `RH_PWM_SPAN_NUM / `RH_PWM_DEN);
    prod = span * {16'h0000, word};
    return 16'(PWM_PERIOD * `RH_PWM_LO_NUM / `RH_PWM_DEN) + prod[31:16];
  endfunction

  // ==========================================================
  // Pin synchronisers and bus events
  logic scl_meta;
  logic scl_sync;
  logic scl_prev;
  logic sda_meta;
  logic sda_sync;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= i_scl;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= i_sda;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign scl_rise = scl_sync & ~scl_prev;
  assign scl_fall = ~scl_sync & scl_prev;
  assign bus_start = !PWM_VARIANT && scl_sync && scl_prev && sda_prev && !sda_sync;
  assign bus_stop = !PWM_VARIANT && scl_sync && scl_prev && !sda_prev && sda_sync;

  // ==========================================================
  // Soft reset
  logic soft_rst;
  logic rst;
  logic cmd_fire;
  logic gcall;
  logic [7:0] cmd;

  assign rst = i_srst | soft_rst;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= cmd_fire && (gcall ? cmd == `RH_GCALL_RESET // RULE17
                                     : cmd == `RH_CMD_SOFT_RST); // RULE16
    end
  end

  // ==========================================================
  // Serial slave
  bus_e bus_st;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic sda_low;
  logic busy;
  logic rd_valid;
  logic rd_pop;
  logic [7:0] rd_data;

  always_ff @(posedge i_clock) begin
    if (rst) begin
      bus_st <= B_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      sda_low <= 1'b0;
      gcall <= 1'b0;
      cmd <= 8'h00;
      cmd_fire <= 1'b0;
      rd_pop <= 1'b0;
    end else begin
      cmd_fire <= 1'b0;
      rd_pop <= 1'b0;
      if (bus_stop) begin
        bus_st <= B_IDLE;
        sda_low <= 1'b0;
      end else if (bus_start) begin
        bus_st <= B_ADDR;
        bitcnt <= 4'h0;
        sda_low <= 1'b0;
      end else begin
        case (bus_st)
          B_ADDR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_sync};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              gcall <= shreg == {`RH_GCALL_ADDR, 1'b0};
              if (shreg == {`RH_GCALL_ADDR, 1'b0} || shreg == {`RH_DEV_ADDR, 1'b0}) begin
                bus_st <= B_AACK;
                sda_low <= 1'b1;
              end else if (shreg == {`RH_DEV_ADDR, 1'b1} && !busy) begin // RULE18
                bus_st <= B_AACK;
                sda_low <= 1'b1;
              end else begin
                bus_st <= B_IDLE;
              end
            end
          end
          B_AACK: begin
            if (scl_fall) begin
              if (shreg[0]) begin
                bus_st <= B_RD;
                shreg <= rd_valid ? rd_data : `RH_IDLE_BYTE;
                sda_low <= rd_valid ? ~rd_data[7] : 1'b0;
                rd_pop <= rd_valid;
              end else begin
                bus_st <= B_WR;
                sda_low <= 1'b0;
              end
            end
          end
          B_WR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_sync};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              bus_st <= B_WACK;
              sda_low <= 1'b1;
              cmd <= shreg;
            end
          end
          B_WACK: begin
            if (scl_fall) begin
              bus_st <= B_WR;
              sda_low <= 1'b0;
              cmd_fire <= 1'b1;
            end
          end
          B_RD: begin
            if (scl_fall) begin
              if (bitcnt == 4'h7) begin
                bitcnt <= 4'h0;
                bus_st <= B_RACK;
                sda_low <= 1'b0;
              end else begin
                bitcnt <= bitcnt + 4'h1;
                shreg <= {shreg[6:0], 1'b0};
                sda_low <= ~shreg[6];
              end
            end
          end
          B_RACK: begin
            if (scl_rise && sda_sync) begin
              bus_st <= B_IDLE;
            end else if (scl_fall) begin
              bus_st <= B_RD;
              shreg <= rd_valid ? rd_data : `RH_IDLE_BYTE;
              sda_low <= rd_valid ? ~rd_data[7] : 1'b0;
              rd_pop <= rd_valid;
            end
          end
          default: begin
            bus_st <= B_IDLE;
            sda_low <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Heater and measurement sequencer
  seq_e seq_st;
  logic [31:0] heat_cnt;
  meas_s result;
  logic [31:0] words;
  logic [2:0] push_idx;
  logic wr_ready;
  logic [7:0] wr_byte;
  logic new_cmd;
  logic flush;

  assign busy = seq_st != Q_IDLE;
  assign new_cmd = cmd_fire && !gcall && !busy;
  assign flush = new_cmd;

  always_ff @(posedge i_clock) begin
    if (rst) begin
      seq_st <= Q_IDLE;
      heat_cnt <= 32'h0000_0000;
      o_heater <= '0;
      o_conv_req <= 1'b0;
      o_conv_rep <= REP_HIGH;
      result <= '0;
      words <= 32'h0000_0000;
      push_idx <= 3'h0;
    end else begin
      case (seq_st)
        Q_IDLE: begin
          if (PWM_VARIANT) begin
            seq_st <= Q_MEAS; // RULE12
            o_conv_req <= 1'b1;
            o_conv_rep <= REP_HIGH;
          end else if (new_cmd) begin
            case (cmd)
              `RH_CMD_MEAS_HI, `RH_CMD_MEAS_MED, `RH_CMD_MEAS_LO: begin
                seq_st <= Q_MEAS;
                o_conv_req <= 1'b1;
                o_conv_rep <= cmd == `RH_CMD_MEAS_HI ? REP_HIGH :
                              cmd == `RH_CMD_MEAS_MED ? REP_MED : REP_LOW;
              end
              `RH_CMD_SERIAL: begin
                seq_st <= Q_PUSH; // RULE3
                words <= SERIAL_NUMBER;
                push_idx <= 3'h0;
              end
              `RH_CMD_H200_L, `RH_CMD_H110_L, `RH_CMD_H20_L: begin
                seq_st <= Q_HEAT; // RULE4 RULE19
                o_heater.on <= 1'b1; // RULE5
                heat_cnt <= 32'(HEAT_LONG_CYC - 1); // RULE8
                o_heater.power <= cmd == `RH_CMD_H200_L ? 2'h2 :
                                  cmd == `RH_CMD_H110_L ? 2'h1 : 2'h0;
              end
              `RH_CMD_H200_S, `RH_CMD_H110_S, `RH_CMD_H20_S: begin
                seq_st <= Q_HEAT; // RULE4 RULE19
                o_heater.on <= 1'b1; // RULE5
                heat_cnt <= 32'(HEAT_SHORT_CYC - 1);
                o_heater.power <= cmd == `RH_CMD_H200_S ? 2'h2 :
                                  cmd == `RH_CMD_H110_S ? 2'h1 : 2'h0;
              end
              default: begin
                seq_st <= Q_IDLE;
              end
            endcase
          end
        end
        Q_HEAT: begin
          if (heat_cnt == 32'h0000_0000) begin
            seq_st <= Q_MEAS; // RULE6
            o_conv_req <= 1'b1;
            o_conv_rep <= REP_HIGH;
          end else begin
            heat_cnt <= heat_cnt - 32'h0000_0001;
          end
        end
        Q_MEAS: begin
          if (i_conv_done) begin
            o_conv_req <= 1'b0;
            o_heater.on <= 1'b0; // RULE7
            result <= i_conv_data; // RULE1
            words <= {i_conv_data.temp, i_conv_data.hum}; // RULE21
            push_idx <= 3'h0;
            seq_st <= PWM_VARIANT ? Q_IDLE : Q_PUSH;
          end
        end
        Q_PUSH: begin
          if (wr_ready) begin
            push_idx <= push_idx + 3'h1;
            if (push_idx == `RH_RESP_LAST) begin
              seq_st <= Q_IDLE; // RULE7
            end
          end
        end
        default: begin
          seq_st <= Q_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Result bytes: high byte, low byte, checksum, per word
  always_comb begin
    case (push_idx)
      3'h0: wr_byte = words[31:24];
      3'h1: wr_byte = words[23:16];
      3'h2: wr_byte = crc8(words[31:16]); // RULE20
      3'h3: wr_byte = words[15:8];
      3'h4: wr_byte = words[7:0];
      3'h5: wr_byte = crc8(words[15:0]); // RULE20
      default: wr_byte = `RH_IDLE_BYTE;
    endcase
  end

  // The builder stalls on a full buffer; unread bytes are dropped only by a reset or by the flush on a new command.
  rh_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_srst(rst),
    .i_flush(flush),
    .i_wr_valid(seq_st == Q_PUSH),
    .o_wr_ready(wr_ready),
    .i_wr_data(wr_byte),
    .o_rd_valid(rd_valid),
    .i_rd_ready(rd_pop),
    .o_rd_data(rd_data)
  );

  // ==========================================================
  // Pulse-width generator
  logic [15:0] pcnt;
  logic [15:0] width_h;
  logic [15:0] width_t;
  logic pwm_valid;
  logic have_result;

  always_ff @(posedge i_clock) begin
    if (rst) begin
      have_result <= 1'b0;
    end else if (seq_st == Q_MEAS && i_conv_done) begin
      have_result <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (rst) begin
      pcnt <= 16'h0000;
      width_h <= 16'h0000;
      width_t <= 16'h0000;
      pwm_valid <= 1'b0;
    end else if (pcnt == 16'(PWM_PERIOD - 1)) begin
      pcnt <= 16'h0000; // RULE13
      width_h <= pwm_width(result.hum); // RULE22 RULE14
      width_t <= pwm_width(result.temp); // RULE22 RULE15
      pwm_valid <= have_result; // RULE12
    end else begin
      pcnt <= pcnt + 16'h0001;
    end
  end

  // ==========================================================
  // Pins: the variant is a build-time choice with no runtime select.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_sda <= 1'b0;
      o_sda_oe <= 1'b0;
      o_scl <= 1'b0;
      o_scl_oe <= 1'b0;
    end else if (PWM_VARIANT) begin
      o_sda <= pwm_valid && pcnt < width_h; // RULE11 RULE13
      o_sda_oe <= 1'b1;
      o_scl <= pwm_valid && pcnt < width_t;
      o_scl_oe <= 1'b1;
    end else begin
      o_sda <= 1'b0;
      o_sda_oe <= sda_low;
      o_scl <= 1'b0;
      o_scl_oe <= 1'b0;
    end
  end
endmodule // rh_readout
`default_nettype wire

// file: rh_cfg.svh
// Purpose: Named constants for the humidity and temperature readout block.
// Assumes: A 100 MHz system clock.
// Notes: Definitions only.
`ifndef RH_CFG_SVH
`define RH_CFG_SVH
// ==========================================================
// Clock and times
`define RH_CLK_KHZ 100_000
`define RH_HEAT_LONG_MS 1000
`define RH_HEAT_SHORT_MS 100
`define RH_HEAT_LONG_CYC (`RH_HEAT_LONG_MS * `RH_CLK_KHZ)
`define RH_HEAT_SHORT_CYC (`RH_HEAT_SHORT_MS * `RH_CLK_KHZ)
`define RH_PWM_PERIOD_CYC 1000
// ==========================================================
// Bus addresses and command codes
`define RH_DEV_ADDR 7'h44
`define RH_GCALL_ADDR 7'h00
`define RH_GCALL_RESET 8'h06
`define RH_CMD_MEAS_HI 8'hFD
`define RH_CMD_MEAS_MED 8'hF6
`define RH_CMD_MEAS_LO 8'hE0
`define RH_CMD_SERIAL 8'h89
`define RH_CMD_SOFT_RST 8'h94
`define RH_CMD_H200_L 8'h39
`define RH_CMD_H200_S 8'h32
`define RH_CMD_H110_L 8'h2F
`define RH_CMD_H110_S 8'h24
`define RH_CMD_H20_L 8'h1E
`define RH_CMD_H20_S 8'h15
// ==========================================================
// Checksum, fill, response length and pulse-width duty values
`define RH_CRC_POLY 8'h31
`define RH_CRC_INIT 8'hFF
`define RH_IDLE_BYTE 8'hFF
`define RH_RESP_LAST 3'h5
`define RH_PWM_LO_NUM 1
`define RH_PWM_SPAN_NUM 8
`define RH_PWM_DEN 10
`endif

// file: rh_pkg.sv
// Purpose: Types shared by the readout block.
// Assumes: Nothing beyond the constants header.
// Notes: Types only.
`default_nettype none
package rh_pkg;
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] hum;
  } meas_s;
  typedef struct packed {
    logic on;
    logic [1:0] power;
  } heater_s;
  typedef enum logic [1:0] {
    REP_LOW = 2'b00,
    REP_MED = 2'b01,
    REP_HIGH = 2'b10
  } rep_e;
  typedef enum logic [2:0] {
    B_IDLE = 3'b000,
    B_ADDR = 3'b001,
    B_AACK = 3'b010,
    B_WR = 3'b011,
    B_WACK = 3'b100,
    B_RD = 3'b101,
    B_RACK = 3'b110
  } bus_e;
  typedef enum logic [1:0] {
    Q_IDLE = 2'b00,
    Q_HEAT = 2'b01,
    Q_MEAS = 2'b10,
    Q_PUSH = 2'b11
  } seq_e;
endpackage
`default_nettype wire

// file: rh_fifo.sv
// Purpose: Byte FIFO between the result builder and the serial transmitter.
// Assumes: One clock; flush empties it at once.
// Notes: Read data comes out of a register and is valid while o_rd_valid is high.
`default_nettype none
module rh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_flush,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW-1:0] next_rptr;
  logic [AW:0] next_count;

  assign push = i_wr_valid & o_wr_ready;
  assign pop = o_rd_valid & i_rd_ready;
  assign next_rptr = rptr + AW'(pop);
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wptr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst || i_flush) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      o_rd_valid <= 1'b0;
      o_wr_ready <= 1'b0;
      o_rd_data <= '0;
    end else begin
      wptr <= wptr + AW'(push);
      rptr <= next_rptr;
      count <= next_count;
      o_rd_valid <= next_count != '0;
      o_wr_ready <= next_count != (AW+1)'(DEPTH);
      // A byte written while the FIFO is or becomes empty is bypassed so the head is never stale.
      o_rd_data <= (push && next_rptr == wptr) ? i_wr_data : mem[next_rptr];
    end
  end
endmodule // rh_fifo
`default_nettype wire

// file: rh_readout_checker.sv
// Purpose: Concurrent checks on the ports of every readout instance.
// Assumes: Heater checks stay idle in the pulse-width build.
// Notes: The on-time ceiling leaves room for the closing measurement.
`default_nettype none
module rh_readout_checker
  import rh_pkg::*;
#(
  parameter int HEAT_LONG_CYC = 200
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic o_scl,
  input wire logic o_scl_oe,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire rh_pkg::heater_s o_heater,
  input wire logic o_conv_req,
  input wire rh_pkg::rep_e o_conv_rep,
  input wire logic i_conv_done,
  input wire rh_pkg::meas_s i_conv_data
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  int on_cnt;
  // ==========================================================
  // Heater on-time count
  always_ff @(posedge i_clock) begin
    if (i_srst || !o_heater.on) begin
      on_cnt <= 0;
    end else begin
      on_cnt <= on_cnt + 1;
    end
  end
  // ==========================================================
  // Heater sequence and pin roles
  a_heat_warm_up: assert property ($rose(o_heater.on) |-> !o_conv_req [*8])
    else $error("measurement started with the heater");
  a_heat_meas_high: assert property (o_heater.on && o_conv_req |-> o_conv_rep == REP_HIGH)
    else $error("heated measurement not high repeatability");
  a_heat_stays_on: assert property (o_heater.on && o_conv_req && !i_conv_done |=> o_heater.on)
    else $error("heater dropped during measurement");
  a_heat_off_done: assert property (o_heater.on && o_conv_req && i_conv_done
    |=> !o_heater.on && !o_conv_req)
    else $error("heater not off after measurement");
  a_heat_max_on: assert property (on_cnt <= HEAT_LONG_CYC + 100)
    else $error("heater on too long");
  a_heat_power_fixed: assert property (o_heater.on && $past(o_heater.on) |-> $stable(o_heater.power))
    else $error("heater power changed while on");
  a_heat_power_legal: assert property ($rose(o_heater.on) |-> o_heater.power != 2'b11)
    else $error("heater power out of range");
  a_pin_role_fixed: assert property (o_scl_oe |=> o_scl_oe && o_sda_oe)
    else $error("pin role changed");
endmodule // rh_readout_checker
bind rh_readout rh_readout_checker #(.HEAT_LONG_CYC(HEAT_LONG_CYC)) u_rh_readout_checker (
  .i_clock(i_clock), .i_srst(i_srst), .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe(o_scl_oe),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_heater(o_heater),
  .o_conv_req(o_conv_req), .o_conv_rep(o_conv_rep), .i_conv_done(i_conv_done),
  .i_conv_data(i_conv_data));
`default_nettype wire

// file: rh_host_model.sv
// Purpose: Bus host and converter models facing the readout block.
// Assumes: The data line has a pull-up; the bus clock idles high between frames.
// Notes: Data moves 20 ns after the clock falls, so the synced lines never fake a start.
`default_nettype none
module rh_host_model (
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    #20 o_sda_low = !b;
    #42.5 o_scl = 1'b1;
    #57.5 s = i_sda_line;
    #5 o_scl = 1'b0;
  endtask
  task automatic start();
    o_sda_low = 1'b1;
    #62.5 o_scl = 1'b0;
  endtask
  task automatic stop();
    #20 o_sda_low = 1'b1;
    #42.5 o_scl = 1'b1;
    #62.5 o_sda_low = 1'b0;
    #62.5;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic get(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule // rh_host_model
module rh_conv_model (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_req,
  input wire logic i_hold,
  input wire rh_pkg::meas_s i_value,
  output logic o_done,
  output rh_pkg::meas_s o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always_ff @(posedge i_clock) begin
    if (i_srst || !i_req || o_done) begin
      cnt <= 0;
      o_done <= 1'b0;
    end else if (!i_hold) begin
      cnt <= cnt + 1;
      o_done <= cnt == 19;
    end
  end
  // Data is only promised beside done, so it is inverted on every cycle without done.
  assign o_data = o_done ? i_value : ~i_value;
endmodule // rh_conv_model
`default_nettype wire

// file: rh_readout_tb_top.sv
// Purpose: Self-checking bench for the bus and pulse-width builds of the readout block.
// Assumes: A host model on the bus pins and a converter model on each build.
// Notes: Heater times are shortened by parameter; expectations use the same values.
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module rh_readout_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rh_pkg::*;
  localparam int LONG = 200;
  localparam int SHORT = 50;
  localparam logic [31:0] SN = 32'hA5C3_0F96; // Arbitrary value.
  logic clk, srst, scl, host_low, sda_oe, req, done, hold, pdone, preq, pscl, psda, pscl_oe;
  heater_s heater;
  rep_e rep;
  meas_s meas, cdata, pmeas, pdata;
  int failures = 0;
  int comparisons = 0;
  int heat_cnt = 0, seen_len = 0;
  logic bscl, bscl_oe, bsda, psda_oe;
  logic [1:0] seen_pow;
  logic [7:0] rx [6];
  wire sda_line = !(host_low || sda_oe);
  rh_readout #(.SERIAL_NUMBER(SN), .HEAT_LONG_CYC(LONG), .HEAT_SHORT_CYC(SHORT),
    .PWM_PERIOD(100)) u_rh_readout (.i_clock(clk), .i_srst(srst), .i_scl(scl), .o_scl(bscl),
    .o_scl_oe(bscl_oe), .i_sda(sda_line), .o_sda(bsda), .o_sda_oe(sda_oe), .o_heater(heater),
    .o_conv_req(req), .o_conv_rep(rep), .i_conv_done(done), .i_conv_data(cdata));
  rh_readout #(.PWM_VARIANT(1'b1), .PWM_PERIOD(100)) u_rh_readout_pwm (.i_clock(clk),
    .i_srst(srst), .i_scl(scl), .o_scl(pscl), .o_scl_oe(pscl_oe), .i_sda(sda_line),
    .o_sda(psda), .o_sda_oe(psda_oe), .o_heater(), .o_conv_req(preq), .o_conv_rep(),
    .i_conv_done(pdone), .i_conv_data(pdata));
  rh_host_model u_rh_host_model (.o_scl(scl), .o_sda_low(host_low), .i_sda_line(sda_line));
  rh_conv_model u_rh_conv_model (.i_clock(clk), .i_srst(srst), .i_req(req), .i_hold(hold),
    .i_value(meas), .o_done(done), .o_data(cdata));
  rh_conv_model u_rh_conv_model_pwm (.i_clock(clk), .i_srst(srst), .i_req(preq),
    .i_hold(hold), .i_value(pmeas), .o_done(pdone), .o_data(pdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The count freezes once the measurement starts, so it holds the warm-up length.
  always @(posedge clk) begin
    if (!heater.on) heat_cnt <= 0;
    else if (!req) heat_cnt <= heat_cnt + 1;
    if (heater.on) seen_len <= heat_cnt;
    if (heater.on) seen_pow <= heater.power;
  end
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  function automatic int exp_w(input logic [15:0] w);
    return 10 + ((80 * int'(w)) >> 16);
  endfunction
  function automatic logic pin(input logic sel);
    return sel ? pscl : psda;
  endfunction
  // ==========================================================
  // Bus helpers
  task automatic wr(input logic [6:0] a, input logic [7:0] c);
    logic k;
    u_rh_host_model.start();
    u_rh_host_model.put({a, 1'b0}, k);
    u_rh_host_model.put(c, k);
    u_rh_host_model.stop();
  endtask
  task automatic rd(input int n);
    logic k;
    k = 1'b0;
    for (int t = 0; t < 300 && !k; t++) begin
      u_rh_host_model.start();
      u_rh_host_model.put({7'h44, 1'b1}, k);
      if (!k) u_rh_host_model.stop();
    end
    for (int i = 0; i < n; i++) u_rh_host_model.get(rx[i], i == n - 1);
    u_rh_host_model.stop();
    `CHK(k, 1'b1)
  endtask
  task automatic words(input logic [15:0] w0, input logic [15:0] w1);
    logic [47:0] e;
    e = {w0, crc8(w0), w1, crc8(w1)};
    for (int i = 0; i < 6; i++) `CHK(rx[i], e[47 - 8 * i -: 8])
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_measure();
    logic [7:0] cmd [3] = '{8'hFD, 8'hF6, 8'hE0};
    for (int i = 0; i < 3; i++) begin
      meas.temp = 16'hBEEF ^ 16'(i);
      meas.hum = 16'hFFFF << i;
      wr(7'h44, cmd[i]);
      rd(6);
      words(meas.temp, meas.hum);
    end
  endtask
  task automatic t_serial();
    wr(7'h44, 8'h89);
    rd(6);
    words(SN[31:16], SN[15:0]);
  endtask
  task automatic t_heater();
    logic [7:0] code [6] = '{8'h39, 8'h32, 8'h2F, 8'h24, 8'h1E, 8'h15};
    int len;
    logic k;
    for (int i = 0; i < 6; i++) begin
      len = (i % 2) ? SHORT : LONG;
      meas.temp = 16'h6E00 + 16'(i);
      meas.hum = 16'h0E00 - 16'(i);
      wr(7'h44, code[i]);
      if (len == LONG) begin
        u_rh_host_model.start();
        u_rh_host_model.put({7'h44, 1'b1}, k);
        u_rh_host_model.stop();
        `CHK(k, 1'b0)
      end
      rd(6);
      words(meas.temp, meas.hum);
      `CHK(heater.on, 1'b0)
      `CHK(seen_pow, 2'(2 - i / 2))
      `CHK(seen_len >= len - 2 && seen_len <= len + 2, 1'b1)
      // Idle for ten heating times keeps the heater duty below its limit.
      repeat (10 * len) @(posedge clk);
    end
  endtask
  task automatic t_resets();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      hold <= 1'b1;
      wr(7'h44, 8'hFD);
      `CHK(req, 1'b1)
      if (i == 0) wr(7'h44, 8'h94);
      else wr(7'h00, 8'h06);
      repeat (4) @(posedge clk);
      `CHK(req, 1'b0)
      hold <= 1'b0;
    end
  endtask
  task automatic width(input logic sel, output int hi, output int per);
    int n;
    for (n = 0; pin(sel) && n < 400; n++) @(posedge clk);
    for (n = 0; !pin(sel) && n < 400; n++) @(posedge clk);
    for (hi = 0; pin(sel) && hi < 400; hi++) @(posedge clk);
    for (per = hi; !pin(sel) && per < 400; per++) @(posedge clk);
  endtask
  task automatic t_pwm();
    logic [15:0] v [4] = '{16'h8000, 16'hFFFF, 16'h4000, 16'h0000};
    int hi, per, et;
    et = 0;
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      pmeas <= {v[2 * j], v[2 * j + 1]};
      for (int k = 0; k < 4 * j; k++) begin
        width(1'b1, hi, per);
        `CHK(hi == et || hi == exp_w(v[2 * j]), 1'b1)
      end
      repeat (300) @(posedge clk);
      width(1'b1, hi, per);
      `CHK(hi, exp_w(v[2 * j]))
      `CHK(per, 100)
      width(1'b0, hi, per);
      `CHK(hi, exp_w(v[2 * j + 1]))
      et = exp_w(v[2 * j]);
    end
    `CHK({pscl_oe, psda_oe, bscl, bscl_oe, bsda}, 5'b11000)
  endtask
  task automatic test_done();
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    hold = 1'b0;
    meas = '0;
    pmeas = 32'h2000_2000;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_measure();
    t_serial();
    t_heater();
    t_resets();
    t_pwm();
    test_done();
  end
  initial begin
    #1_000_000;
    failures++;
    test_done();
  end
endmodule // rh_readout_tb_top
`default_nettype wire
